// ---- common/fcsp_defs.svh ----
// Register offsets, field positions, command codes and timing counts for the flash sequencer
`ifndef FCSP_DEFS_SVH
`define FCSP_DEFS_SVH
`define FCSP_OFF_PROT     12'h000
`define FCSP_OFF_STAT     12'h004
`define FCSP_OFF_CMD      12'h008
`define FCSP_OFF_DIV      12'h00c
`define FCSP_OFF_ADDR     12'h010
`define FCSP_OFF_DATA     12'h014
`define FCSP_OFF_INTMASK  12'h018
`define FCSP_OFF_INTSTAT  12'h01c
`define FCSP_OFF_CTRL     12'h020
`define FCSP_ST_CBEF      7
`define FCSP_ST_CCF       6
`define FCSP_ST_PVIOL     5
`define FCSP_ST_ACCERR    4
`define FCSP_ST_BLANK     2
`define FCSP_CMD_BLANK    8'h05
`define FCSP_CMD_BYTE     8'h20
`define FCSP_CMD_BURST    8'h25
`define FCSP_CMD_PAGE     8'h40
`define FCSP_CMD_MASS     8'h41
`define FCSP_PULSES_PROG  16'h0008
`define FCSP_PULSES_PAGE  16'h0040
`define FCSP_PULSES_MASS  16'h0100
`define FCSP_PULSES_BLANK 16'h0010
`define FCSP_ADDR_W       16
`endif

// ---- common/fcsp_pkg.sv ----
// Types shared by the flash sequencer
package fcsp_pkg;
  typedef enum logic [1:0] {FCSP_IDLE, FCSP_RUN} fcsp_state_t;
endpackage

// ---- src/fcsp_flash_seq.sv ----
// Flash command, status and protection register block with APB slave
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fcsp_defs.svh"
module fcsp_flash_seq
  import fcsp_pkg::*;
(
  input  wire logic        clk,            // Bus clock, 40 MHz
  input  wire logic        rst_n,          // Asynchronous reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB access phase
  input  wire logic        pwrite,         // APB direction
  input  wire logic [11:0] paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error on unmapped address
  input  wire logic [7:0]  storedProtByte, // Nonvolatile protection byte
  input  wire logic        dbgProtWr,      // Debug write strobe to protection
  input  wire logic [7:0]  dbgProtData,    // Debug write data
  input  wire logic        stopReq,        // Stop mode entry, same clock
  input  wire logic        arrayErased,    // Array reads all erased
  output logic             flashClkEn,     // One-cycle flash clock enable
  output logic             progStrobe,     // Array operation start pulse
  output logic [7:0]       opCode,         // Command in the array
  output logic [15:0]      opAddr,         // Target address
  output logic [7:0]       opData,         // Program data
  output logic             irq             // Level interrupt
);
  logic [7:0]  protection;
  logic        protLoaded;
  logic        bufferEmpty, cmdComplete, protViol, accErr, blankFlag;
  logic [7:0]  cmdReg;
  logic [15:0] addrReg;
  logic [7:0]  dataReg;
  logic        prdiv8, divInit;
  logic [5:0]  divField;
  logic [4:0]  intMask, intStat;
  fcsp_state_t state;
  logic [15:0] pulses;
  logic [2:0]  pre8;
  logic [5:0]  divCnt;
  logic        pendValid;
  logic [7:0]  pendCode;
  logic [15:0] pendAddr;
  logic [7:0]  pendData;

  wire wrEn = psel & penable & pwrite;
  wire rdMapped = (paddr <= `FCSP_OFF_CTRL) && (paddr[1:0] == 2'b00);

  // Protected when enabled and address above the boundary end
  function automatic logic isProtected(input logic [7:0] p, input logic [15:0] a);
    isProtected = ~p[0] && (a[15:9] > p[7:1]);
  endfunction

  // Recognised codes
  function automatic logic isLegal(input logic [7:0] c);
    isLegal = (c == `FCSP_CMD_BLANK) || (c == `FCSP_CMD_BYTE) ||
              (c == `FCSP_CMD_BURST) || (c == `FCSP_CMD_PAGE) ||
              (c == `FCSP_CMD_MASS);
  endfunction

  function automatic logic [15:0] pulseCount(input logic [7:0] c);
    unique case (c)
      `FCSP_CMD_BLANK: pulseCount = `FCSP_PULSES_BLANK;
      `FCSP_CMD_PAGE:  pulseCount = `FCSP_PULSES_PAGE;
      `FCSP_CMD_MASS:  pulseCount = `FCSP_PULSES_MASS;
      default:         pulseCount = `FCSP_PULSES_PROG;
    endcase
  endfunction

  wire launch   = wrEn && (paddr == `FCSP_OFF_STAT) && pwdata[`FCSP_ST_CBEF] && bufferEmpty;
  wire isErase  = (cmdReg == `FCSP_CMD_PAGE) || (cmdReg == `FCSP_CMD_MASS);
  wire isProg   = (cmdReg == `FCSP_CMD_BYTE) || (cmdReg == `FCSP_CMD_BURST) || isErase;
  // A running non-burst command accepts no second command
  wire seqErr   = (state == FCSP_RUN) && ((opCode != `FCSP_CMD_BURST) ||
                  (cmdReg != `FCSP_CMD_BURST));
  wire badCmd   = ~isLegal(cmdReg) || seqErr || (isProg && ~divInit);
  wire violCmd  = isProg && (cmdReg != `FCSP_CMD_MASS || ~protection[0]) &&
                  (cmdReg == `FCSP_CMD_MASS ? ~protection[0] : isProtected(protection, addrReg));
  wire goodLaunch = launch && ~badCmd && ~violCmd;
  wire startOp  = (state == FCSP_IDLE) && (pendValid || goodLaunch);
  wire finishOp = (state == FCSP_RUN) && flashClkEn && (pulses == 16'h0001);
  wire stopErr  = stopReq && (state == FCSP_RUN);

  // Flash clock divider: bus, optional divide by eight, then divider plus one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre8 <= 3'h0;
      divCnt <= 6'h00;
    end
    else
    begin
      if (!prdiv8 || pre8 == 3'h7)
      begin
        divCnt <= (divCnt >= divField) ? 6'h00 : divCnt + 6'h01;
      end
      pre8 <= prdiv8 ? pre8 + 3'h1 : 3'h0;
    end
  end
  assign flashClkEn = (!prdiv8 || pre8 == 3'h7) && (divCnt >= divField);

  // Protection: captured just after reset release since async reset takes constants only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      protection <= 8'hff;
      protLoaded <= 1'b0;
    end
    else if (!protLoaded)
    begin
      protection <= storedProtByte;
      protLoaded <= 1'b1;
    end
    else if (dbgProtWr)
    begin
      protection <= dbgProtData;
    end
    else if (wrEn && paddr == `FCSP_OFF_PROT && !protection[0])
    begin
      if (pwdata[7:1] < protection[7:1])
        protection[7:1] <= pwdata[7:1];
    end
  end

  // Clock divider settings; first write marks the divider initialised
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdiv8 <= 1'b0;
      divField <= 6'h00;
      divInit <= 1'b0;
    end
    else if (wrEn && paddr == `FCSP_OFF_DIV && !divInit)
    begin
      prdiv8 <= pwdata[6];
      divField <= pwdata[5:0];
      divInit <= 1'b1;
    end
  end

  // Command, address and data capture; writes while the buffer is full are dropped
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmdReg <= 8'h00;
      addrReg <= 16'h0000;
      dataReg <= 8'h00;
    end
    else if (wrEn && bufferEmpty)
    begin
      if (paddr == `FCSP_OFF_CMD) cmdReg <= pwdata[7:0];
      if (paddr == `FCSP_OFF_ADDR) addrReg <= pwdata[15:0];
      if (paddr == `FCSP_OFF_DATA) dataReg <= pwdata[7:0];
    end
  end

  // One-deep buffer holds a launched command until the array is free
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pendValid <= 1'b0;
      pendCode <= 8'h00;
      pendAddr <= 16'h0000;
      pendData <= 8'h00;
    end
    else if (stopErr)
      pendValid <= 1'b0;
    else if (goodLaunch && (state == FCSP_RUN || pendValid))
    begin
      pendValid <= 1'b1;
      pendCode <= cmdReg;
      pendAddr <= addrReg;
      pendData <= dataReg;
    end
    else if (startOp)
      pendValid <= 1'b0;
  end

  // Array sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= FCSP_IDLE;
      pulses <= 16'h0000;
      opCode <= 8'h00;
      opAddr <= 16'h0000;
      opData <= 8'h00;
      progStrobe <= 1'b0;
    end
    else
    begin
      progStrobe <= 1'b0;
      unique case (state)
        FCSP_IDLE:
          if (startOp)
          begin
            state <= FCSP_RUN;
            opCode <= pendValid ? pendCode : cmdReg;
            opAddr <= pendValid ? pendAddr : addrReg;
            opData <= pendValid ? pendData : dataReg;
            pulses <= pulseCount(pendValid ? pendCode : cmdReg);
            progStrobe <= 1'b1;
          end
        FCSP_RUN:
          if (stopErr)
            state <= FCSP_IDLE;
          else if (flashClkEn)
          begin
            pulses <= pulses - 16'h0001;
            if (pulses == 16'h0001)
              state <= FCSP_IDLE;
          end
      endcase
    end
  end

  // Buffer-empty: cleared on launch, set again once the launched command sits in the array,
  // so a second burst can be queued while the first one is still programming
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bufferEmpty <= 1'b1;
    else if (goodLaunch)
      bufferEmpty <= 1'b0;
    else if (!bufferEmpty && (!pendValid || startOp || stopErr))
      bufferEmpty <= 1'b1;
  end

  // Completion: set once idle with empty buffer, ignores writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cmdComplete <= 1'b1;
    else if (goodLaunch)
      cmdComplete <= 1'b0;
    else if (state == FCSP_IDLE && !pendValid && bufferEmpty)
      cmdComplete <= 1'b1;
  end

  // Error flags: a new error wins over a same-cycle write-one clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      protViol <= 1'b0;
      accErr <= 1'b0;
    end
    else
    begin
      if (launch && !badCmd && violCmd)
        protViol <= 1'b1;
      else if (wrEn && paddr == `FCSP_OFF_STAT && pwdata[`FCSP_ST_PVIOL])
        protViol <= 1'b0;
      if ((launch && badCmd) || stopErr)
        accErr <= 1'b1;
      else if (wrEn && paddr == `FCSP_OFF_STAT && pwdata[`FCSP_ST_ACCERR])
        accErr <= 1'b0;
    end
  end

  // Blank result
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      blankFlag <= 1'b0;
    else if (goodLaunch)
      blankFlag <= 1'b0;
    else if (finishOp && opCode == `FCSP_CMD_BLANK)
      blankFlag <= arrayErased;
  end

  // Interrupt status: completion, buffer empty, violation, access error, blank
  wire [4:0] events = {finishOp & (opCode == `FCSP_CMD_BLANK) & arrayErased,
                       (launch && badCmd) || stopErr,
                       launch && !badCmd && violCmd,
                       startOp && pendValid,
                       finishOp && !pendValid};
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      intStat <= 5'h00;
      intMask <= 5'h00;
    end
    else
    begin
      intStat <= events | (intStat &
        ~((wrEn && paddr == `FCSP_OFF_INTSTAT) ? pwdata[4:0] : 5'h00));
      if (wrEn && paddr == `FCSP_OFF_INTMASK)
        intMask <= pwdata[4:0];
    end
  end
  assign irq = |(intStat & intMask);

  // APB: zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign pslverr = psel && penable && !rdMapped;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        `FCSP_OFF_PROT:    prdata <= {24'h000000, protection};
        `FCSP_OFF_STAT:    prdata <= {24'h000000, bufferEmpty, cmdComplete, protViol,
                                       accErr, 1'b0, blankFlag, 2'b00};
        `FCSP_OFF_CMD:     prdata <= {24'h000000, cmdReg};
        `FCSP_OFF_DIV:     prdata <= {24'h000000, divInit, prdiv8, divField};
        `FCSP_OFF_ADDR:    prdata <= {16'h0000, addrReg};
        `FCSP_OFF_DATA:    prdata <= {24'h000000, dataReg};
        `FCSP_OFF_INTMASK: prdata <= {27'h0000000, intMask};
        `FCSP_OFF_INTSTAT: prdata <= {27'h0000000, intStat};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- test/fcsp_flash_seq_asserts.sv ----
// Port checks for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fcsp_defs.svh"
module fcsp_flash_seq_asserts
(
  input wire logic        clk,        // Clock
  input wire logic        rst_n,      // Reset
  input wire logic        psel,       // Select
  input wire logic        penable,    // Access
  input wire logic        pwrite,     // Direction
  input wire logic [11:0] paddr,      // Address
  input wire logic [31:0] prdata,     // Read data
  input wire logic        pready,     // Ready
  input wire logic        pslverr,    // Error
  input wire logic        flashClkEn, // Tick
  input wire logic        progStrobe, // Op start
  input wire logic [7:0]  opCode,     // Op code
  input wire logic        irq         // Interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Status read in access phase
  wire logic stRd = psel && penable && !pwrite && paddr == `FCSP_OFF_STAT;
  // Bus answer and error mapping
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_err_map: assert property (psel && penable |->
    pslverr == (paddr > 12'h020 || paddr[1:0] != 2'b00)) else $error("bad pslverr");
  chk_err_phase: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  chk_rdata_hold: assert property (!psel |=> $stable(prdata)) else $error("prdata moved");
  chk_irq_reset: assert property ($rose(rst_n) |-> !irq) else $error("irq after reset");
  // Complete only while the buffer is empty
  chk_done_empty: assert property (stRd && prdata[6] |-> prdata[7])
    else $error("complete with full buffer");
  chk_strobe_pulse: assert property (progStrobe |=> !progStrobe) else $error("long strobe");
  chk_strobe_code: assert property (progStrobe |-> opCode inside {`FCSP_CMD_BLANK,
    `FCSP_CMD_BYTE, `FCSP_CMD_BURST, `FCSP_CMD_PAGE, `FCSP_CMD_MASS}) else $error("bad op");
  // Slowest divider gives a tick every 512 cycles
  chk_tick_after: assert property (progStrobe |-> ##[0:600] flashClkEn)
    else $error("no flash tick");
  cover property (progStrobe && opCode == `FCSP_CMD_BLANK);
  cover property (pslverr);
  cover property (irq);
endmodule
bind fcsp_flash_seq fcsp_flash_seq_asserts fcsp_flash_seq_asserts_inst (.clk, .rst_n, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .flashClkEn, .progStrobe, .opCode,
  .irq);
`default_nettype wire

// ---- test/fcsp_flash_seq_bench.sv ----
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fcsp_defs.svh"
module fcsp_flash_seq_bench
  import fcsp_pkg::*;
;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, err, flashClkEn, progStrobe, irq;
  logic        dbgProtWr = 0, stopReq = 0, arrayErased = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0]  storedProtByte = '0, dbgProtData = '0, opCode, opData;
  logic [15:0] opAddr;
  int          miscompares = 0, cmp_count = 0, b;
  int          code[$] = '{5, 32, 37, 64, 65};
  logic [31:0] expOp[$];   // Model: {code, address, data} of accepted commands in order
  logic [31:0] expWord;
  always #12.5 clk = ~clk;
  fcsp_flash_seq fcsp_flash_seq_inst (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .storedProtByte, .dbgProtWr, .dbgProtData,
    .stopReq, .arrayErased, .flashClkEn, .progStrobe, .opCode, .opAddr, .opData, .irq);
  // Every array start must match the oldest command that the rules accept
  always @(posedge clk)
  begin
    if (rst_n && progStrobe)
    begin
      expWord = (expOp.size() > 0) ? expOp.pop_front() : 32'hxxxxxxxx;
      chk({opCode, opAddr, opData}, expWord);
    end
  end
  task end_of_test;
    $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One APB transfer; data taken at the edge where pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40)
    begin
      miscompares++;
      end_of_test();
    end
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(rd & m, e);
  endtask
  // Irq is looked at once the write edge has landed
  task ckirq(input logic e);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task dbg(input logic [7:0] v);
    @(posedge clk);
    dbgProtWr <= 1'b1;
    dbgProtData <= v;
    @(posedge clk);
    dbgProtWr <= 1'b0;
  endtask
  // Load and launch a command; ok says whether the rules let it reach the array
  task cmd(input logic [7:0] c, input logic [15:0] a, input bit ok);
    logic [31:0] d;
    d = $urandom;
    apb(1'b1, `FCSP_OFF_ADDR, {16'h0, a});
    apb(1'b1, `FCSP_OFF_DATA, d);
    apb(1'b1, `FCSP_OFF_CMD, {24'h0, c});
    if (ok)
      expOp.push_back({c, a, d[7:0]});
    apb(1'b1, `FCSP_OFF_STAT, 32'h80);
  endtask
  // Poll the complete flag under a bound; a mass erase at 200 kHz needs about 17000 polls
  task wdone;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `FCSP_OFF_STAT, '0);
      n++;
    end
    while (rd[6] !== 1'b1 && n < 20000);
    if (n >= 20000)
    begin
      miscompares++;
      end_of_test();
    end
  endtask
  initial
  begin
    void'($urandom(32'had84cb6f));
    b = $urandom_range(120, 8);
    storedProtByte = {b[6:0], 1'b0};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(`FCSP_OFF_PROT, 32'hff, {b[6:0], 1'b0});
    rdc(`FCSP_OFF_STAT, 32'hf4, 32'hc0);
    // Raising the boundary is refused, lowering it takes
    apb(1'b1, `FCSP_OFF_PROT, {b[6:0] + 7'h01, 1'b0});
    rdc(`FCSP_OFF_PROT, 32'hff, {b[6:0], 1'b0});
    b = b - 3;
    apb(1'b1, `FCSP_OFF_PROT, {b[6:0], 1'b1});
    rdc(`FCSP_OFF_PROT, 32'hff, {b[6:0], 1'b0});
    dbg(8'h01);
    rdc(`FCSP_OFF_PROT, 32'hff, 32'h01);
    apb(1'b1, `FCSP_OFF_PROT, '0);
    rdc(`FCSP_OFF_PROT, 32'hff, 32'h01);
    $display("Test protection done");
    // Program before the divider is set, then flag clearing
    cmd(`FCSP_CMD_BYTE, 16'h1234, 1'b0);
    rdc(`FCSP_OFF_STAT, 32'hf4, 32'hd0);
    apb(1'b1, `FCSP_OFF_STAT, '0);
    rdc(`FCSP_OFF_STAT, 32'hf4, 32'hd0);
    apb(1'b1, `FCSP_OFF_STAT, 32'h10);
    rdc(`FCSP_OFF_STAT, 32'hf4, 32'hc0);
    // Bus divided by 8 and by 25 keeps the flash clock at 200 kHz
    apb(1'b1, `FCSP_OFF_DIV, 32'h58);
    apb(1'b1, `FCSP_OFF_INTMASK, 32'h1f);
    cmd(8'h33, 16'h0, 1'b0);
    rdc(`FCSP_OFF_STAT, 32'hf4, 32'hd0);
    ckirq(1'b1);
    apb(1'b1, `FCSP_OFF_STAT, 32'h10);
    apb(1'b1, `FCSP_OFF_INTSTAT, 32'h1f);
    ckirq(1'b0);
    $display("Test access error done");
    // Every code; blank sets after blank check, next command clears it
    @(posedge clk);
    arrayErased <= 1'b1;
    foreach (code[i])
    begin
      cmd(code[i][7:0], 16'($urandom_range(16'hffff, 0)), 1'b1);
      wdone();
      rdc(`FCSP_OFF_STAT, 32'hf4, code[i] == 5 ? 32'hc4 : 32'hc0);
    end
    apb(1'b1, `FCSP_OFF_INTMASK, '0);
    ckirq(1'b0);
    apb(1'b1, `FCSP_OFF_INTMASK, 32'h1f);
    ckirq(1'b1);
    apb(1'b1, `FCSP_OFF_INTSTAT, 32'h1f);
    ckirq(1'b0);
    $display("Test commands done");
    // Second burst loaded while the first one runs
    cmd(`FCSP_CMD_BURST, 16'h0100, 1'b1);
    rdc(`FCSP_OFF_STAT, 32'hc0, 32'h80);
    cmd(`FCSP_CMD_BURST, 16'h0101, 1'b1);
    wdone();
    rdc(`FCSP_OFF_STAT, 32'hf4, 32'hc0);
    // Boundary zero with protection on guards the upper pages
    dbg(8'h00);
    cmd(`FCSP_CMD_BYTE, 16'h0200, 1'b0);
    rdc(`FCSP_OFF_STAT, 32'hf4, 32'he0);
    apb(1'b1, `FCSP_OFF_STAT, 32'h20);
    rdc(`FCSP_OFF_STAT, 32'hf4, 32'hc0);
    // Stop entry during a mass erase
    dbg(8'h01);
    cmd(`FCSP_CMD_MASS, 16'h0, 1'b1);
    stopReq <= 1'b1;
    wdone();
    stopReq <= 1'b0;
    rdc(`FCSP_OFF_STAT, 32'hf4, 32'hd0);
    rdc(12'h030, 32'hffffffff, '0);
    chk({31'h0, err}, 32'h1);
    chk(expOp.size(), 32'h0);
    $display("Test burst, violation, stop done");
    end_of_test();
  end
endmodule
`default_nettype wire
